// ### logic/eppce_engine.sv
// EPP cycle engine: host port registers and EPP 1.9 / 1.7 parallel cycles
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "eppce_consts.svh"

// Notes on behaviour
// - In 1.9, ready drops at every EPP cycle start, released when completion known.
// - In 1.9, if wait is high at start, wait for it low before strobing.
// - 1.9 write: drive byte, direction low, nWrite low, then assert strobe; here all switch on one edge when wait is low at start.
// - Wait high in 1.9 write: drop strobe, latch byte, release ready.
// - 1.9 read: float bus, nWrite high, direction high, then assert strobe; here all switch on one edge when wait is low at start.
// - Wait high in 1.9 read: capture byte, drop strobe, return byte, release ready; here ready rises one clock before the byte reaches the host bus.
// - Outside EPP cycles the port follows control register and direction bit.
// - 1.7 watchdog aborts cycles over 10 us and sets timeout status bit 0.
// - In 1.7, ready is held low while wait is low during a cycle.
// - 1.7 write: direction bit low asserts nWrite; host write drives strobe.
// - 1.7 write strobe holds until host write ends, byte latched then.
// - 1.7 read: direction bit floats bus; strobe follows host read.
// - nWrite, data strobe and address strobe are active-low outputs.
// - Peripheral interrupt passes through without inversion, rising-edge active.
// - Direction output low for write, high when direction bit or EPP read.
// - Only nWrite and direction may be overridden by control register during a cycle.
// - Active-low reset output returns the peripheral to its initial mode.
// - 1.9 watchdog times out over 10 us until wait high; abort, set bit 0.
// - Reset or writing one clears timeout flag; writing zero does nothing.
// - Standard strobe active during an EPP cycle forces write direction and nWrite.
module eppce_engine #(
  parameter int TIMEOUT_CYCLES = `EPPCE_TIMEOUT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic epp_enable_in,
  input wire logic epp17_mode_in,
  input wire logic [2:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  output logic [7:0] host_data_bus_out,
  output logic host_ready_out,
  output logic [7:0] parallel_data_lines_out,
  output logic parallel_data_oe_out,
  input wire logic [7:0] parallel_data_bus_in,
  output logic port_direction_out,
  output logic write_n_out,
  output logic data_strobe_n_out,
  output logic addr_strobe_n_out,
  output logic strobe_n_out,
  output logic autofd_n_out,
  output logic periph_reset_n_out,
  output logic select_in_n_out,
  input wire logic wait_n_in,
  input wire logic peripheral_interrupt_in,
  input wire logic [4:0] status_pins_in,
  output logic peripheral_interrupt_out
);
  initial begin
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin
      $error("TIMEOUT_CYCLES out of range");
    end
  end

  eppce_pkg::eppce_state_e state_q, state_d;
  logic [15:0] wd_cnt_q;
  logic [5:0] ctrl_q;
  logic [7:0] spp_data_q;
  logic [7:0] out_byte_q;
  logic [7:0] rd_data_q;
  logic timeout_flag_q;
  logic is_read_q;
  logic is_addr_q;
  logic rd_hold_q;
  logic wait_hi;
  logic [7:0] dout_q;
  logic rdy_q;
  logic oe_q;
  logic dir_q;
  logic wr_n_q;
  logic ds_n_q;
  logic as_n_q;
  logic peripheral_interrupt_in_q;
  logic [4:0] ctl_n_q;

  // Wait arrives from the peripheral without regard to our clock
  eppce_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_wait_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(~wait_n_in),
    .sync_out(wait_hi)
  );

  function automatic logic is_epp_addr(input logic [2:0] a);
    is_epp_addr = (a >= `EPPCE_OFF_EADDR);
  endfunction

  // Decode of host accesses
  wire epp_wr = epp_enable_in & host_wr_in & is_epp_addr(host_addr_in);
  wire epp_rd = epp_enable_in & host_rd_in & is_epp_addr(host_addr_in);
  wire epp_start = (epp_wr | epp_rd) & (state_q == eppce_pkg::EPPCE_IDLE);
  wire addr_sel = (host_addr_in == `EPPCE_OFF_EADDR);
  wire host_active = host_wr_in | host_rd_in;
  wire wd_expired = (wd_cnt_q >= 16'(TIMEOUT_CYCLES));
  wire in_cycle = (state_q != eppce_pkg::EPPCE_IDLE);
  wire strobing = (state_q == eppce_pkg::EPPCE_STROBE) | (state_q == eppce_pkg::EPPCE_HOLD);
  wire spp_strobe = ctrl_q[`EPPCE_CTL_STROBE];
  wire clr_timeout = host_wr_in & (host_addr_in == `EPPCE_OFF_STATUS)
                     & host_wdata_in[`EPPCE_STS_TIMEOUT];
  // The 1.7 host sustains its strobe, so the cycle ends at host release
  wire done17 = epp17_mode_in & ~host_active;
  // Wait is "low" in 1.9 terms when the peripheral is ready (wait_hi is inverted)
  wire wait_ready = wait_hi;
  wire periph_ack = ~wait_hi;

  // Cycle sequencing for both protocol variants
  always_comb begin
    state_d = state_q;
    case (state_q)
      eppce_pkg::EPPCE_IDLE: begin
        if (epp_start) begin
          if (epp17_mode_in) begin
            state_d = eppce_pkg::EPPCE_STROBE;
          end else if (wait_ready) begin
            state_d = eppce_pkg::EPPCE_STROBE;
          end else begin
            state_d = eppce_pkg::EPPCE_WAIT_LOW;
          end
        end
      end
      eppce_pkg::EPPCE_WAIT_LOW: begin
        if (wd_expired) begin
          state_d = eppce_pkg::EPPCE_ABORT;
        end else if (wait_ready) begin
          state_d = eppce_pkg::EPPCE_STROBE;
        end
      end
      eppce_pkg::EPPCE_STROBE: begin
        if (wd_expired) begin
          state_d = eppce_pkg::EPPCE_ABORT;
        end else if (epp17_mode_in) begin
          if (done17) begin
            state_d = eppce_pkg::EPPCE_IDLE;
          end
        end else if (periph_ack) begin
          state_d = eppce_pkg::EPPCE_DONE;
        end
      end
      eppce_pkg::EPPCE_DONE: begin
        if (~host_active) begin
          state_d = eppce_pkg::EPPCE_IDLE;
        end
      end
      eppce_pkg::EPPCE_ABORT: begin
        if (~host_active) begin
          state_d = eppce_pkg::EPPCE_IDLE;
        end
      end
      default: begin
        state_d = eppce_pkg::EPPCE_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= eppce_pkg::EPPCE_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Watchdog restarts with each cycle and counts while one runs
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wd_cnt_q <= 16'h0000;
    end else if (epp_start) begin
      wd_cnt_q <= 16'h0000;
    end else if (in_cycle && !wd_expired) begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  // Timeout flag: a new timeout wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timeout_flag_q <= 1'b0;
    end else if (state_d == eppce_pkg::EPPCE_ABORT && state_q != eppce_pkg::EPPCE_ABORT) begin
      timeout_flag_q <= 1'b1;
    end else if (clr_timeout) begin
      timeout_flag_q <= 1'b0;
    end
  end

  // Cycle kind latched at start
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      is_read_q <= 1'b0;
      is_addr_q <= 1'b0;
    end else if (epp_start) begin
      is_read_q <= epp_rd;
      is_addr_q <= addr_sel;
    end
  end

  // Standard registers; the EPP byte registers clear at reset
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `EPPCE_CTRL_RESET;
      spp_data_q <= 8'h00;
      out_byte_q <= 8'h00;
    end else begin
      if (host_wr_in && host_addr_in == `EPPCE_OFF_CTRL) begin
        ctrl_q <= host_wdata_in[5:0];
      end
      if (host_wr_in && host_addr_in == `EPPCE_OFF_DATA) begin
        spp_data_q <= host_wdata_in;
      end
      if (epp_wr) begin
        out_byte_q <= host_wdata_in;
      end
    end
  end

  // Read byte is captured off the parallel bus as the peripheral acknowledges
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_q <= 8'h00;
      rd_hold_q <= 1'b0;
    end else if (strobing && is_read_q && (periph_ack || done17) && !rd_hold_q) begin
      rd_data_q <= parallel_data_bus_in;
      rd_hold_q <= 1'b1;
    end else if (state_q == eppce_pkg::EPPCE_IDLE) begin
      rd_hold_q <= 1'b0;
    end
  end

  // Output pin values; strobes only while the engine holds a cycle
  wire dir_eff = in_cycle ? ((is_read_q & ~spp_strobe) | (ctrl_q[`EPPCE_CTL_DIR] & epp17_mode_in
                 & ~spp_strobe)) : ctrl_q[`EPPCE_CTL_DIR];
  wire wr_n_eff = in_cycle ? ((is_read_q | (epp17_mode_in & ctrl_q[`EPPCE_CTL_DIR]))
                  & ~spp_strobe) : 1'b1;
  // Strobe only while the engine stays in STROBE; byte, nWrite and direction switch on the same edge as it unless it first waits in EPPCE_WAIT_LOW
  wire stb_on = (state_q == eppce_pkg::EPPCE_STROBE)
                & (state_d == eppce_pkg::EPPCE_STROBE);
  wire rdy_d = ~(epp_start | (state_q == eppce_pkg::EPPCE_WAIT_LOW)
               | (state_q == eppce_pkg::EPPCE_STROBE & ~epp17_mode_in & ~periph_ack)
               | (state_q == eppce_pkg::EPPCE_STROBE & epp17_mode_in & wait_hi & ~wd_expired))
               | (state_d == eppce_pkg::EPPCE_ABORT) | (state_d == eppce_pkg::EPPCE_DONE);
  wire [7:0] dout_d = in_cycle ? out_byte_q : spp_data_q;
  wire [7:0] rd_mux = (host_addr_in == `EPPCE_OFF_STATUS) ?
                      {status_pins_in, 2'b00, timeout_flag_q} :
                      (host_addr_in == `EPPCE_OFF_CTRL) ? {2'b00, ctrl_q} :
                      is_epp_addr(host_addr_in) ? rd_data_q : spp_data_q;

  // Registered pins keep glitches off the cable and the host bus
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdy_q <= 1'b1;
      oe_q <= 1'b1;
      dir_q <= 1'b0;
      wr_n_q <= 1'b1;
      ds_n_q <= 1'b1;
      as_n_q <= 1'b1;
      dout_q <= 8'h00;
      peripheral_interrupt_in_q <= 1'b0;
      ctl_n_q <= 5'h1f;
      host_data_bus_out <= 8'h00;
    end else begin
      rdy_q <= rdy_d;
      dir_q <= dir_eff;
      oe_q <= ~dir_eff;
      wr_n_q <= wr_n_eff;
      ds_n_q <= ~(stb_on & ~is_addr_q);
      as_n_q <= ~(stb_on & is_addr_q);
      dout_q <= dout_d;
      peripheral_interrupt_in_q <= peripheral_interrupt_in;
      ctl_n_q <= {~ctrl_q[`EPPCE_CTL_SLCTIN], ctrl_q[`EPPCE_CTL_INIT],
                  ~ctrl_q[`EPPCE_CTL_AUTOFD], ~ctrl_q[`EPPCE_CTL_STROBE], 1'b0};
      host_data_bus_out <= rd_hold_q && host_rd_in && is_epp_addr(host_addr_in) ?
                           rd_data_q : rd_mux;
    end
  end

  assign host_ready_out = rdy_q;
  assign parallel_data_oe_out = oe_q;
  assign parallel_data_lines_out = dout_q;
  assign port_direction_out = dir_q;
  assign write_n_out = wr_n_q;
  assign data_strobe_n_out = ds_n_q;
  assign addr_strobe_n_out = as_n_q;
  assign strobe_n_out = ctl_n_q[1];
  assign autofd_n_out = ctl_n_q[2];
  assign periph_reset_n_out = ctl_n_q[3];
  assign select_in_n_out = ctl_n_q[4];
  assign peripheral_interrupt_out = peripheral_interrupt_in_q;
endmodule

// ### logic/eppce_consts.svh
// Constants for the EPP cycle engine: offsets, fields, reset values, timing
`ifndef EPPCE_CONSTS_SVH
`define EPPCE_CONSTS_SVH
`define EPPCE_OFF_DATA 3'h0
`define EPPCE_OFF_STATUS 3'h1
`define EPPCE_OFF_CTRL 3'h2
`define EPPCE_OFF_EADDR 3'h3
`define EPPCE_OFF_EDATA0 3'h4
`define EPPCE_OFF_MODE 3'h0
`define EPPCE_CTL_STROBE 0
`define EPPCE_CTL_AUTOFD 1
`define EPPCE_CTL_INIT 2
`define EPPCE_CTL_SLCTIN 3
`define EPPCE_CTL_DIR 5
`define EPPCE_STS_TIMEOUT 0
`define EPPCE_CTRL_RESET 6'h04
`define EPPCE_TIMEOUT_NS 10000
`define EPPCE_CLK_PERIOD_NS 10
`define EPPCE_TIMEOUT_CYCLES (`EPPCE_TIMEOUT_NS / `EPPCE_CLK_PERIOD_NS)
`endif

// ### logic/eppce_pkg.sv
// Types for the EPP cycle engine
package eppce_pkg;
  typedef enum logic [5:0] {
    EPPCE_IDLE = 6'h01,
    EPPCE_WAIT_LOW = 6'h02,
    EPPCE_STROBE = 6'h04,
    EPPCE_HOLD = 6'h08,
    EPPCE_DONE = 6'h10,
    EPPCE_ABORT = 6'h20
  } eppce_state_e;
endpackage

// ### logic/eppce_sync.sv
// Two flip-flop synchroniser for asynchronous peripheral levels
`timescale 1ns/1ps
module eppce_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ### test/eppce_periph_model.sv
// Behavioural EPP peripheral answering strobes with the wait handshake
`timescale 1ns/1ps
module eppce_periph_model (
  input wire logic clk_in,
  input wire logic dstb_n_in,
  input wire logic astb_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic [2:0] delay_in,
  input wire logic stuck_in,
  input wire logic hold_hi_in,
  output logic wait_n_out,
  output logic [7:0] bus_out,
  output logic [7:0] got_out,
  output logic early_out
);
  logic stb;
  logic [3:0] cnt_q;
  assign stb = !dstb_n_in || !astb_n_in;
  initial {wait_n_out, bus_out, got_out, early_out, cnt_q} = '0;
  // Wait rises after a steerable delay; stuck_in models a dead peripheral
  always @(posedge clk_in) begin
    early_out <= early_out || (hold_hi_in && stb);
    if (hold_hi_in) begin
      wait_n_out <= 1'b1;
    end else if (stb) begin
      cnt_q <= cnt_q + 4'h1;
      if (!wr_n_in) got_out <= data_in;
      if (wr_n_in) bus_out <= rd_byte_in;
      if (cnt_q > {1'b0, delay_in} && !stuck_in) wait_n_out <= 1'b1;
    end else begin
      cnt_q <= 4'h0;
      bus_out <= ~bus_out;
      wait_n_out <= 1'b0;
    end
  end
endmodule

// ### test/eppce_engine_properties.sv
// Port-level properties of the EPP cycle engine
`timescale 1ns/1ps
module eppce_engine_properties #(
  parameter int TIMEOUT_CYCLES = 1000
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic epp_enable_in,
  input wire logic epp17_mode_in,
  input wire logic [2:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input logic host_ready_out,
  input logic parallel_data_oe_out,
  input logic port_direction_out,
  input logic write_n_out,
  input logic data_strobe_n_out,
  input logic addr_strobe_n_out,
  input wire logic wait_n_in,
  input wire logic peripheral_interrupt_in,
  input logic peripheral_interrupt_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic stb;
  int lo_q;
  assign stb = !data_strobe_n_out || !addr_strobe_n_out;
  // Length of each host stall; only the watchdog keeps it finite
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) lo_q <= 0;
    else lo_q <= host_ready_out ? 0 : lo_q + 1;
  end
  chk_ready_drops: assert property ($rose(host_wr_in || host_rd_in) && epp_enable_in
    && !epp17_mode_in && host_addr_in >= 3'h3 |=> !host_ready_out) else $error("no stall");
  chk_write_drive: assert property (stb && !write_n_out |->
    !port_direction_out && parallel_data_oe_out) else $error("write not driven");
  chk_read_float: assert property (stb && write_n_out |->
    port_direction_out && !parallel_data_oe_out) else $error("read not floated");
  chk_strobe_kind: assert property ($fell(addr_strobe_n_out) |->
    host_addr_in == 3'h3 && data_strobe_n_out) else $error("wrong strobe");
  chk_release_order: assert property ($rose(host_ready_out) && !epp17_mode_in |->
    !stb) else $error("ready before strobe end");
  chk_wait_gate: assert property (!epp17_mode_in && $rose(stb) |->
    !$past(wait_n_in) && !$past(wait_n_in, 2)) else $error("strobe while wait high");
  chk_strobe_hold: assert property (epp17_mode_in && host_wr_in && host_ready_out
    && !data_strobe_n_out |=> !data_strobe_n_out) else $error("strobe ended early");
  chk_irq_pass: assert property (peripheral_interrupt_out ==
    $past(peripheral_interrupt_in)) else $error("interrupt not passed");
  chk_watchdog_cut: assert property (lo_q <= TIMEOUT_CYCLES + 4)
    else $error("stall not cut");
endmodule
bind eppce_engine eppce_engine_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
  .sys_clk_in, .sys_rst_in, .epp_enable_in, .epp17_mode_in, .host_addr_in, .host_wr_in,
  .host_rd_in, .host_ready_out, .parallel_data_oe_out, .port_direction_out, .write_n_out,
  .data_strobe_n_out, .addr_strobe_n_out, .wait_n_in, .peripheral_interrupt_in,
  .peripheral_interrupt_out);

// ### test/epp_cycle_engine_tb.sv
// Self-checking bench for the EPP cycle engine with a peripheral model
`timescale 1ns/1ps
module epp_cycle_engine_tb;
  localparam int TO = 20;
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, epp_enable_in = 1'b0, epp17_mode_in = 1'b0;
  logic host_wr_in = 1'b0, host_rd_in = 1'b0, peripheral_interrupt_in = 1'b0;
  logic look = 1'b0, stuck = 1'b0, hold = 1'b0;
  logic [2:0] host_addr_in = 3'h0, dly = 3'h0;
  logic [4:0] status_pins_in = 5'h00;
  logic [7:0] host_wdata_in = 8'h00, rbyte = 8'h00, v, host_data_bus_out, pbus, got;
  logic [7:0] parallel_data_lines_out, parallel_data_bus_in;
  logic host_ready_out, parallel_data_oe_out, port_direction_out, write_n_out, wait_n_in;
  logic data_strobe_n_out, addr_strobe_n_out, strobe_n_out, autofd_n_out, early;
  logic periph_reset_n_out, select_in_n_out, peripheral_interrupt_out;
  logic [7:0] exp_q[$];
  int errors = 0, checks_done = 0, cyc = 0;
  integer seed = 32'h2306;
  assign parallel_data_bus_in = parallel_data_oe_out ? parallel_data_lines_out : pbus;
  eppce_engine #(.TIMEOUT_CYCLES(TO)) dut_u (.sys_clk_in, .sys_rst_in, .epp_enable_in,
    .epp17_mode_in, .host_addr_in, .host_wdata_in, .host_wr_in, .host_rd_in,
    .host_data_bus_out, .host_ready_out, .parallel_data_lines_out, .parallel_data_oe_out,
    .parallel_data_bus_in, .port_direction_out, .write_n_out, .data_strobe_n_out,
    .addr_strobe_n_out, .strobe_n_out, .autofd_n_out, .periph_reset_n_out, .select_in_n_out,
    .wait_n_in, .peripheral_interrupt_in, .status_pins_in, .peripheral_interrupt_out);
  eppce_periph_model peer_u (.clk_in(sys_clk_in), .dstb_n_in(data_strobe_n_out),
    .astb_n_in(addr_strobe_n_out), .wr_n_in(write_n_out), .data_in(parallel_data_bus_in),
    .rd_byte_in(rbyte), .delay_in(dly), .stuck_in(stuck), .hold_hi_in(hold),
    .wait_n_out(wait_n_in), .bus_out(pbus), .got_out(got), .early_out(early));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    host_addr_in <= a;
    host_wdata_in <= d;
    host_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    host_wr_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    host_addr_in <= a;
    host_rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_in);
    host_rd_in <= 1'b0;
    look <= 1'b1;
    @(posedge sys_clk_in);
    look <= 1'b0;
  endtask
  // Host holds its strobe through the cycle, as an ISA master stretched by ready
  task automatic epp(input logic [2:0] a, input logic rd, input logic [7:0] d, input int hd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    host_addr_in <= a;
    host_wdata_in <= d;
    host_rd_in <= rd;
    host_wr_in <= !rd;
    repeat (2) @(posedge sys_clk_in);
    while (host_ready_out !== 1'b1 && n < 200) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk("ready return", 1, n < 200);
    repeat (hd) @(posedge sys_clk_in);
    if (rd) exp_q.push_back(rbyte);
    look <= rd;
    host_rd_in <= 1'b0;
    host_wr_in <= 1'b0;
    @(posedge sys_clk_in);
    look <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  // Oldest noted read value against what the host bus shows
  always @(posedge sys_clk_in) begin
    if (look) chk("host data", exp_q.pop_front(), host_data_bus_out);
  end
  // Cycle ceiling far above the planned run; a hang lands in the report
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    status_pins_in <= 5'($random(seed));
    rd_reg(3'h2, 8'h04);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      peripheral_interrupt_in <= v[7];
      wr_reg(3'h2, v);
      repeat (2) @(posedge sys_clk_in);
      chk("ctl pins", {2'b00, v[5], 1'b0, ~v[3], v[2], ~v[1], ~v[0]}, {2'b00,
        port_direction_out, 1'b0, select_in_n_out, periph_reset_n_out, autofd_n_out,
        strobe_n_out});
      rd_reg(3'h2, {2'b00, v[5:0]});
      rd_reg(3'h1, {status_pins_in, 3'b000});
    end
    $display("test spp done");
    wr_reg(3'h2, 8'h04);
    epp_enable_in <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      v = 8'($random(seed));
      dly <= v[2:0];
      rbyte <= ~v;
      epp(3'h3 + 3'(i % 5), 1'b0, v, 0);
      chk("peer byte", v, got);
      epp(3'h3 + 3'(i % 5), 1'b1, 8'h00, 0);
    end
    hold <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    fork
      epp(3'h4, 1'b0, 8'h3c, 0);
      begin
        repeat (8) @(posedge sys_clk_in);
        hold <= 1'b0;
      end
    join
    chk("early strobe", 0, early);
    chk("peer byte", 8'h3c, got);
    stuck <= 1'b1;
    epp(3'h4, 1'b0, 8'h11, 0);
    stuck <= 1'b0;
    rd_reg(3'h1, {status_pins_in, 3'b001});
    wr_reg(3'h1, 8'h00);
    rd_reg(3'h1, {status_pins_in, 3'b001});
    wr_reg(3'h1, 8'h01);
    rd_reg(3'h1, {status_pins_in, 3'b000});
    $display("test epp19 done");
    epp17_mode_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      dly <= v[2:0];
      epp(3'h3 + 3'(i), 1'b0, v, 3);
      chk("peer byte", v, got);
    end
    wr_reg(3'h2, 8'h24);
    epp(3'h4, 1'b1, 8'h00, 2);
    wr_reg(3'h2, 8'h04);
    stuck <= 1'b1;
    epp(3'h5, 1'b0, 8'h22, 0);
    stuck <= 1'b0;
    rd_reg(3'h1, {status_pins_in, 3'b001});
    epp_enable_in <= 1'b0;
    wr_reg(3'h4, 8'h77);
    @(posedge sys_clk_in);
    chk("idle strobe", 1, data_strobe_n_out);
    $display("test epp17 done");
    give_verdict();
  end
endmodule
